//--- pkg/smr_consts.svh
`ifndef SMR_CONSTS_SVH
`define SMR_CONSTS_SVH
// Settling select codes
`define SMR_SETTLE_SEL_12 3'h0
`define SMR_SETTLE_SEL_15 3'h2
`define SMR_SETTLE_SEL_17 3'h4
// Settling cycle counts
`define SMR_SETTLE_CNT_12 18'h01000
`define SMR_SETTLE_CNT_15 18'h08000
`define SMR_SETTLE_CNT_17 18'h20000
// Reset values
`define SMR_RST_STATUS_WORD 8'h02
`define SMR_RST_CLOCK_CTRL 8'h02
`define SMR_RST_SETTLE_SEL 8'h04
`define SMR_RST_PORT_LATCH 8'h00
`define SMR_RST_PULLUP 8'h00
`define SMR_RST_PORT_DIR 8'hff
`define SMR_RST_IRQ_FLAGS 8'h00
`define SMR_RST_IRQ_MASK 8'hff
`define SMR_RST_EDGE_MODE 8'h00
`define SMR_RST_DISP_MODE_0 8'h10
`define SMR_RST_DISP_MODE_1 8'h01
`define SMR_RST_DISP_MODE_2 8'h00
`define SMR_RST_PERIPH_MODE 8'h00
// Reset vector addresses
`define SMR_VEC_LO_ADDR 16'h0000
`define SMR_VEC_HI_ADDR 16'h0001
// Least external reset width
`define SMR_RST_MIN_US 10
`define SMR_CLK_MHZ 100
`define SMR_RST_MIN_CYC (`SMR_RST_MIN_US * `SMR_CLK_MHZ)
`endif

//--- pkg/smr_pkg.sv
`default_nettype none
package smr_pkg;
  typedef enum logic [2:0] {
    SMR_RUN = 3'b000,
    SMR_STOP = 3'b001,
    SMR_HALT = 3'b010,
    SMR_SETTLE = 3'b011,
    SMR_RESET = 3'b100,
    SMR_VECTOR = 3'b101
  } smr_state_t;
  typedef enum logic [1:0] {
    SMR_RES_NONE = 2'b00,
    SMR_RES_NEXT = 2'b01,
    SMR_RES_IRQ = 2'b10,
    SMR_RES_RESET = 2'b11
  } smr_resume_t;
endpackage
`default_nettype wire

//--- verilog/smr_stop_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "smr_consts.svh"
module smr_stop_reset_ctrl
  import smr_pkg::*;
#(
  parameter int SETTLE_CNT_12 = `SMR_SETTLE_CNT_12,
  parameter int SETTLE_CNT_15 = `SMR_SETTLE_CNT_15,
  parameter int SETTLE_CNT_17 = `SMR_SETTLE_CNT_17,
  parameter int RST_MIN_CYC = `SMR_RST_MIN_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic resetPinN,
  input wire logic watchdogOverflow,
  input wire logic stopInstr,
  input wire logic subClockSelected,
  input wire logic serialExtClock,
  input wire logic [7:0] irqPending,
  input wire logic [7:0] vectorByte,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  output logic [15:0] vectorAddr,
  output logic [15:0] program_counter,
  output logic programCounterValid,
  output logic cpuRun,
  output logic oscEnable,
  output logic crystal_out_pin_pullup,
  output logic pinsHighZ,
  output logic portLatchHold,
  output logic timersRun,
  output logic displayRun,
  output logic watchTimerRun,
  output logic serialRun,
  output logic resumeVector,
  output logic resumeNext,
  output logic resetSeqActive,
  output logic [2:0] stateOut
);
  // ****************************************************************
  // Register map (byte index on the register port)
  // ****************************************************************
  localparam logic [7:0] A_SETTLE = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h01;
  localparam logic [7:0] A_CLK = 8'h02;
  localparam logic [7:0] A_MASK = 8'h03;
  localparam logic [7:0] A_FLAGS = 8'h04;
  localparam logic [7:0] A_EDGE = 8'h05;
  localparam logic [7:0] A_DIR = 8'h06;
  localparam logic [7:0] A_LATCH = 8'h07;
  localparam logic [7:0] A_PULLUP = 8'h08;
  localparam logic [7:0] A_DISP0 = 8'h09;
  localparam logic [7:0] A_DISP1 = 8'h0a;
  localparam logic [7:0] A_DISP2 = 8'h0b;
  localparam logic [7:0] A_STATE = 8'h0c;
  localparam int ST_IE_BIT = 7;

  smr_state_t state_q;
  smr_state_t state_d;
  logic [17:0] settleCnt_q;
  logic [17:0] settleLimit_q;
  logic [15:0] rstLowCnt_q;
  logic rstValid_q;
  logic afterReset_q;
  logic [1:0] resume_q;
  logic [7:0] settleSel_q;
  logic [7:0] statusWord_q;
  logic [7:0] clockCtrl_q;
  logic [7:0] irqMask_q;
  logic [7:0] irqFlags_q;
  logic [7:0] edgeMode_q;
  logic [7:0] portDir_q;
  logic [7:0] portLatch_q;
  logic [7:0] pullup_q;
  logic [7:0] disp0_q;
  logic [7:0] disp1_q;
  logic [7:0] disp2_q;
  logic [7:0] vecLo_q;
  logic [7:0] rdata_q;
  logic unmaskedReq;
  logic resetReq;
  logic settleDone;
  logic regsWritable;

  // ****************************************************************
  // Reset sources
  // ****************************************************************
  // Pin pulses shorter than the least width are not taken as reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstLowCnt_q <= 16'h0000;
      rstValid_q <= 1'b0;
    end else if (resetPinN) begin
      rstLowCnt_q <= 16'h0000;
      rstValid_q <= 1'b0;
    end else if (rstLowCnt_q >= 16'(RST_MIN_CYC - 1)) begin
      rstValid_q <= 1'b1;
    end else begin
      rstLowCnt_q <= rstLowCnt_q + 16'h0001;
    end
  end

  assign resetReq = rstValid_q || watchdogOverflow;
  assign unmaskedReq = |(irqFlags_q & ~irqMask_q);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign settleDone = (settleCnt_q >= settleLimit_q - 18'h00001);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SMR_RUN: begin
        if (stopInstr && unmaskedReq) begin
          state_d = SMR_HALT;
        end else if (stopInstr) begin
          state_d = SMR_STOP;
        end
      end
      SMR_STOP: begin
        if (unmaskedReq) begin
          state_d = SMR_SETTLE;
        end
      end
      SMR_HALT: state_d = SMR_SETTLE;
      SMR_SETTLE: begin
        if (settleDone) begin
          state_d = (resume_q == SMR_RES_RESET) ? SMR_VECTOR : SMR_RUN;
        end
      end
      SMR_RESET: begin
        if (!resetReq) begin
          state_d = SMR_SETTLE;
        end
      end
      SMR_VECTOR: state_d = SMR_RUN;
      default: state_d = SMR_RESET;
    endcase
    if (resetReq) begin
      state_d = SMR_RESET;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= SMR_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Count clears on every entry so each wait starts from oscillation restart
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      settleCnt_q <= 18'h00000;
    end else if (state_q != SMR_SETTLE) begin
      settleCnt_q <= 18'h00000;
    end else if (!settleDone) begin
      settleCnt_q <= settleCnt_q + 18'h00001;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      settleLimit_q <= 18'(SETTLE_CNT_15);
      afterReset_q <= 1'b1;
      resume_q <= SMR_RES_RESET;
    end else if (state_q == SMR_RESET) begin
      settleLimit_q <= 18'(SETTLE_CNT_15);
      resume_q <= SMR_RES_RESET;
      afterReset_q <= 1'b1;
    end else if (state_d == SMR_SETTLE && state_q != SMR_SETTLE) begin
      afterReset_q <= 1'b0;
      resume_q <= statusWord_q[ST_IE_BIT] ? SMR_RES_IRQ : SMR_RES_NEXT;
      unique case (settleSel_q[2:0])
        `SMR_SETTLE_SEL_12: settleLimit_q <= 18'(SETTLE_CNT_12);
        `SMR_SETTLE_SEL_15: settleLimit_q <= 18'(SETTLE_CNT_15);
        default: settleLimit_q <= 18'(SETTLE_CNT_17);
      endcase
    end
  end

  // ****************************************************************
  // Program counter load from vector table
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      vecLo_q <= 8'h00;
      program_counter <= 16'h0000;
      programCounterValid <= 1'b0;
    end else if (state_d == SMR_RESET) begin
      programCounterValid <= 1'b0;
    end else if (state_q == SMR_SETTLE && resume_q == SMR_RES_RESET) begin
      vecLo_q <= vectorByte;
    end else if (state_q == SMR_VECTOR) begin
      program_counter <= {vectorByte, vecLo_q};
      programCounterValid <= 1'b1;
    end
  end

  assign vectorAddr = (state_q == SMR_VECTOR) ? `SMR_VEC_HI_ADDR : `SMR_VEC_LO_ADDR;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Writes take effect only in run; standby contents stay put under reset until the vector state reloads defaults
  assign regsWritable = (state_q == SMR_RUN) && regWrite;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      settleSel_q <= `SMR_RST_SETTLE_SEL;
      statusWord_q <= `SMR_RST_STATUS_WORD;
      clockCtrl_q <= `SMR_RST_CLOCK_CTRL;
      portDir_q <= `SMR_RST_PORT_DIR;
      portLatch_q <= `SMR_RST_PORT_LATCH;
      pullup_q <= `SMR_RST_PULLUP;
      disp0_q <= `SMR_RST_DISP_MODE_0;
      disp1_q <= `SMR_RST_DISP_MODE_1;
      disp2_q <= `SMR_RST_DISP_MODE_2;
    end else if (state_q == SMR_VECTOR) begin
      settleSel_q <= `SMR_RST_SETTLE_SEL;
      statusWord_q <= `SMR_RST_STATUS_WORD;
      clockCtrl_q <= `SMR_RST_CLOCK_CTRL;
      portDir_q <= `SMR_RST_PORT_DIR;
      portLatch_q <= `SMR_RST_PORT_LATCH;
      pullup_q <= `SMR_RST_PULLUP;
      disp0_q <= `SMR_RST_DISP_MODE_0;
      disp1_q <= `SMR_RST_DISP_MODE_1;
      disp2_q <= `SMR_RST_DISP_MODE_2;
    end else if (regsWritable) begin
      unique case (regAddr)
        A_SETTLE: settleSel_q <= {5'h00, regWdata[2:0]};
        A_STATUS: statusWord_q <= regWdata;
        A_CLK: clockCtrl_q <= regWdata;
        A_DIR: portDir_q <= regWdata;
        A_LATCH: portLatch_q <= regWdata;
        A_PULLUP: pullup_q <= regWdata;
        A_DISP0: disp0_q <= regWdata;
        A_DISP1: disp1_q <= regWdata;
        A_DISP2: disp2_q <= regWdata;
        default: ;
      endcase
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irqFlags_q <= `SMR_RST_IRQ_FLAGS;
      irqMask_q <= `SMR_RST_IRQ_MASK;
      edgeMode_q <= `SMR_RST_EDGE_MODE;
    end else if (state_q == SMR_VECTOR) begin
      irqFlags_q <= `SMR_RST_IRQ_FLAGS;
      irqMask_q <= `SMR_RST_IRQ_MASK;
      edgeMode_q <= `SMR_RST_EDGE_MODE;
    end else begin
      if (regsWritable && regAddr == A_FLAGS) begin
        irqFlags_q <= regWdata | irqPending;
      end else begin
        irqFlags_q <= irqFlags_q | irqPending;
      end
      if (regsWritable && regAddr == A_MASK) begin
        irqMask_q <= regWdata;
      end
      if (regsWritable && regAddr == A_EDGE) begin
        edgeMode_q <= regWdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        A_SETTLE: rdata_q <= settleSel_q;
        A_STATUS: rdata_q <= statusWord_q;
        A_CLK: rdata_q <= clockCtrl_q;
        A_MASK: rdata_q <= irqMask_q;
        A_FLAGS: rdata_q <= irqFlags_q;
        A_EDGE: rdata_q <= edgeMode_q;
        A_DIR: rdata_q <= portDir_q;
        A_LATCH: rdata_q <= portLatch_q;
        A_PULLUP: rdata_q <= pullup_q;
        A_DISP0: rdata_q <= disp0_q;
        A_DISP1: rdata_q <= disp1_q;
        A_DISP2: rdata_q <= disp2_q;
        A_STATE: rdata_q <= {5'h00, state_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign regRdata = rdata_q;

  // ****************************************************************
  // Unit controls
  // ****************************************************************
  logic inStop;
  assign inStop = (state_q == SMR_STOP);
  assign oscEnable = !inStop;
  assign cpuRun = (state_q == SMR_RUN);
  assign crystal_out_pin_pullup = inStop;
  assign portLatchHold = inStop || (state_q == SMR_HALT);
  assign timersRun = (state_q == SMR_RUN) || (state_q == SMR_HALT);
  assign displayRun = !inStop;
  assign watchTimerRun = inStop ? subClockSelected : 1'b1;
  assign serialRun = inStop ? serialExtClock : 1'b1;
  // Ports float in reset and its settling wait; retained state is untouched
  assign pinsHighZ = (state_q == SMR_RESET) || (state_q == SMR_VECTOR) ||
                     ((state_q == SMR_SETTLE) && (resume_q == SMR_RES_RESET));
  assign resumeVector = (state_q == SMR_SETTLE) && settleDone && (resume_q == SMR_RES_IRQ);
  assign resumeNext = (state_q == SMR_SETTLE) && settleDone && (resume_q == SMR_RES_NEXT);
  assign resetSeqActive = (state_q == SMR_RESET);
  assign stateOut = state_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  stop_entry_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == SMR_RUN && state_d == SMR_STOP) |-> stopInstr && !unmaskedReq)
    else $error("standby entered without stop instruction");
  stop_pullup_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    inStop |-> crystal_out_pin_pullup && !oscEnable && !cpuRun)
    else $error("standby outputs wrong");
  halt_first_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == SMR_RUN && stopInstr && unmaskedReq && !resetReq) |=>
    state_q == SMR_HALT ##1 state_q == SMR_SETTLE)
    else $error("pending request did not give halt");
  masked_stays_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (inStop && !unmaskedReq && !resetReq) |=> inStop)
    else $error("masked request left standby");
  reset_enter_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    watchdogOverflow |=> state_q == SMR_RESET && pinsHighZ)
    else $error("watchdog did not reset");
  reset_limit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == SMR_RESET && !resetReq) |=> state_q == SMR_SETTLE && settleLimit_q == 18'(SETTLE_CNT_15))
    else $error("post-reset settle limit wrong");
  settle_count_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == SMR_SETTLE && !settleDone && !resetReq) |=> settleCnt_q == $past(settleCnt_q) + 18'h00001)
    else $error("settle counter stalled");
  mask_reset_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_q == SMR_VECTOR) |=> irqMask_q == `SMR_RST_IRQ_MASK && programCounterValid)
    else $error("reset values not loaded");
endmodule
`default_nettype wire

//--- verification/smr_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module smr_far_side #(
  parameter int RST_MIN_CYC = 4
) (
  input wire logic ref_clk,
  input wire logic [15:0] vectorAddr,
  output logic [7:0] vectorByte,
  output logic resetPinN,
  output logic watchdogOverflow,
  output logic [7:0] irqPending
);
  logic [7:0] vecMem [2];
  initial begin
    vecMem[0] = 8'h34;
    vecMem[1] = 8'h12;
    resetPinN = 1'b1;
    watchdogOverflow = 1'b0;
    irqPending = 8'h00;
  end
  // Only the two vector bytes exist; any other address returns the inverted low address byte
  assign vectorByte = (vectorAddr[15:1] == 15'h0000) ? vecMem[vectorAddr[0]] : ~vectorAddr[7:0];
  // ***************
  // Request tasks
  // ***************
  task automatic pin_reset(input int n);
    int len;
    len = (n < RST_MIN_CYC) ? RST_MIN_CYC : n;
    @(posedge ref_clk);
    resetPinN <= 1'b0;
    repeat (len) @(posedge ref_clk);
    resetPinN <= 1'b1;
  endtask
  task automatic pulse_irq(input logic [7:0] src);
    @(posedge ref_clk);
    irqPending <= src;
    @(posedge ref_clk);
    irqPending <= 8'h00;
  endtask
  // The overflow must drop again, or the reset would never clear
  task automatic wdog_overflow();
    @(posedge ref_clk);
    watchdogOverflow <= 1'b1;
    @(posedge ref_clk);
    watchdogOverflow <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/stop_mode_and_reset_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module stop_mode_and_reset_control_test;
  import smr_pkg::*;
  localparam int SC12 = 16;
  localparam int SC15 = 32;
  localparam int SC17 = 64;
  localparam int RMIN = 4;
  typedef struct packed {logic [7:0] addr; logic [7:0] val;} smr_row_t;
  logic ref_clk, resetn, resetPinN, watchdogOverflow, stopInstr, subClockSelected, serialExtClock;
  logic [7:0] irqPending, vectorByte, regAddr, regWdata, regRdata;
  logic regWrite, regRead, programCounterValid, cpuRun, oscEnable, crystal_out_pin_pullup, pinsHighZ;
  logic portLatchHold, timersRun, displayRun, watchTimerRun, serialRun, resumeVector, resumeNext;
  logic resetSeqActive;
  logic [15:0] vectorAddr, program_counter;
  logic [2:0] stateOut;
  int nMismatch = 0;
  int checkCount = 0;
  smr_row_t rows [14] = '{'{8'h00, 8'h04}, '{8'h01, 8'h02}, '{8'h02, 8'h02}, '{8'h03, 8'hff},
    '{8'h04, 8'h00}, '{8'h05, 8'h00}, '{8'h06, 8'hff}, '{8'h07, 8'h00}, '{8'h08, 8'h00},
    '{8'h09, 8'h10}, '{8'h0a, 8'h01}, '{8'h0b, 8'h00}, '{8'h0c, 8'h00}, '{8'h20, 8'h00}};
  smr_stop_reset_ctrl #(.SETTLE_CNT_12(SC12), .SETTLE_CNT_15(SC15), .SETTLE_CNT_17(SC17), .RST_MIN_CYC(RMIN)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .resetPinN(resetPinN), .watchdogOverflow(watchdogOverflow),
    .stopInstr(stopInstr), .subClockSelected(subClockSelected), .serialExtClock(serialExtClock),
    .irqPending(irqPending), .vectorByte(vectorByte), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .vectorAddr(vectorAddr),
    .program_counter(program_counter), .programCounterValid(programCounterValid), .cpuRun(cpuRun),
    .oscEnable(oscEnable), .crystal_out_pin_pullup(crystal_out_pin_pullup), .pinsHighZ(pinsHighZ),
    .portLatchHold(portLatchHold), .timersRun(timersRun), .displayRun(displayRun),
    .watchTimerRun(watchTimerRun), .serialRun(serialRun), .resumeVector(resumeVector),
    .resumeNext(resumeNext), .resetSeqActive(resetSeqActive), .stateOut(stateOut));
  smr_far_side #(.RST_MIN_CYC(RMIN)) far_u (.ref_clk(ref_clk), .vectorAddr(vectorAddr),
    .vectorByte(vectorByte), .resetPinN(resetPinN), .watchdogOverflow(watchdogOverflow), .irqPending(irqPending));
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  // ***************
  // Helpers
  // ***************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_span(input int got, input int lo, input int hi);
    checkCount++;
    if (got < lo || got > hi) begin
      nMismatch++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic wait_state(input smr_state_t s, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (stateOut !== s && n < 500);
  endtask
  task automatic wait_resume(output int n, output logic [1:0] kind);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
      kind = {resumeNext, resumeVector};
    end while (kind !== 2'b10 && kind !== 2'b01 && n < 500);
  endtask
  task automatic stop_now();
    @(posedge ref_clk);
    stopInstr <= 1'b1;
    @(posedge ref_clk);
    stopInstr <= 1'b0;
    #1;
  endtask
  // Settle wait after any reset is the SETTLE_CNT_15 one whatever the select holds
  task automatic after_reset();
    int n;
    logic [7:0] d;
    chk({15'h0, programCounterValid}, 16'h0000);
    wait_state(SMR_RUN, n);
    chk_span(n, SC15, SC15 + 5);
    chk(program_counter, 16'h1234);
    reg_rd(8'h00, d);
    chk({8'h0, d}, 16'h0004);
    reg_rd(8'h03, d);
    chk({8'h0, d}, 16'h00ff);
  endtask
  task automatic test_done();
    if (nMismatch == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ***************
  // Main sequence
  // ***************
  initial begin
    logic [7:0] d;
    int n;
    logic [1:0] kind;
    resetn = 1'b0;
    stopInstr = 1'b0;
    subClockSelected = 1'b1;
    serialExtClock = 1'b1;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (12) @(posedge ref_clk);
    chk({14'h0, pinsHighZ, cpuRun}, 16'h0002);
    resetn <= 1'b1;
    after_reset();
    foreach (rows[i]) begin
      reg_rd(rows[i].addr, d);
      chk({8'h0, d}, {8'h0, rows[i].val});
    end
    reg_wr(8'h00, 8'h00);
    reg_wr(8'h03, 8'hfe);
    stop_now();
    chk({13'h0, stateOut}, {13'h0, SMR_STOP});
    chk({cpuRun, oscEnable, crystal_out_pin_pullup, portLatchHold, timersRun, displayRun, watchTimerRun,
      serialRun}, 16'h0033);
    @(posedge ref_clk);
    subClockSelected <= 1'b0;
    serialExtClock <= 1'b0;
    @(posedge ref_clk);
    #1 chk({watchTimerRun, serialRun}, 16'h0000);
    far_u.pulse_irq(8'h02);
    repeat (4) @(posedge ref_clk);
    #1 chk({13'h0, stateOut}, {13'h0, SMR_STOP});
    far_u.pulse_irq(8'h01);
    wait_resume(n, kind);
    chk_span(n, SC12 - 1, SC12 + 4);
    chk({14'h0, kind}, 16'h0002);
    stop_now();
    chk({15'h0, oscEnable}, 16'h0001);
    wait_resume(n, kind);
    chk_span(n, SC12 - 2, SC12 + 4);
    reg_wr(8'h04, 8'h00);
    reg_wr(8'h01, 8'h82);
    stop_now();
    far_u.pulse_irq(8'h01);
    wait_resume(n, kind);
    chk({14'h0, kind}, 16'h0001);
    reg_wr(8'h04, 8'h00);
    stop_now();
    // Pin must stay low past the filter before the reset state is entered
    fork
      far_u.pin_reset(RMIN + 2);
      begin
        repeat (2) @(posedge ref_clk);
        #1 chk({12'h0, pinsHighZ, stateOut}, {13'h0, SMR_STOP});
        repeat (4) @(posedge ref_clk);
        #1 chk({14'h0, pinsHighZ, resetSeqActive}, 16'h0003);
        reg_rd(8'h03, d);
        chk({8'h0, d}, 16'h00fe);
      end
    join
    #1 chk({15'h0, pinsHighZ}, 16'h0001);
    after_reset();
    reg_wr(8'h00, 8'h00);
    reg_wr(8'h03, 8'h00);
    far_u.wdog_overflow();
    #1 chk({14'h0, pinsHighZ, resetSeqActive}, 16'h0003);
    after_reset();
    reg_wr(8'h03, 8'hfe);
    stop_now();
    far_u.pulse_irq(8'h01);
    wait_resume(n, kind);
    chk_span(n, SC17 - 1, SC17 + 4);
    chk({14'h0, kind}, 16'h0002);
    test_done();
  end
  initial begin
    #100us;
    nMismatch++;
    test_done();
  end
endmodule
`default_nettype wire
